// ### pag_defines.vh
`ifndef PAG_DEFINES_VH
`define PAG_DEFINES_VH

// register offsets on the register access port
`define PAG_ADDR_W           10
`define PAG_OFS_RAMP         10'h3a7
`define PAG_OFS_BRIDGE       10'h3a8
`define PAG_OFS_EXT_BIAS     10'h3a9
`define PAG_OFS_EXT_LEVEL    10'h3aa
`define PAG_OFS_ADC_RBK      10'h3ae
`define PAG_OFS_LNA_FREEZE   10'h3b2
`define PAG_OFS_SAT_MARGIN   10'h3b4
`define PAG_OFS_UPPER_TRIG   10'h3b6
`define PAG_OFS_TARGET       10'h3b7
`define PAG_OFS_LOWER_TRIG   10'h3b8
`define PAG_OFS_RSSI_TRIM    10'h3b9
`define PAG_OFS_POSTFILTER   10'h3ba

// reset values, reserved bits included
`define PAG_RST_RAMP         8'h07
`define PAG_RST_BRIDGE       8'h0d
`define PAG_RST_EXT_BIAS     8'h00
`define PAG_RST_EXT_LEVEL    8'hf1
`define PAG_RST_LNA_FREEZE   8'h30
`define PAG_RST_SAT_MARGIN   8'h90
`define PAG_RST_UPPER_TRIG   8'h2e
`define PAG_RST_TARGET       8'h23
`define PAG_RST_LOWER_TRIG   8'h18
`define PAG_RST_RSSI_TRIM    8'h13
`define PAG_RST_POSTFILTER   8'h2d

// index of each read/write register in the bank
`define PAG_NUM_RW           11
`define PAG_IDX_RAMP         0
`define PAG_IDX_BRIDGE       1
`define PAG_IDX_EXT_BIAS     2
`define PAG_IDX_EXT_LEVEL    3
`define PAG_IDX_LNA_FREEZE   4
`define PAG_IDX_SAT_MARGIN   5
`define PAG_IDX_UPPER_TRIG   6
`define PAG_IDX_TARGET       7
`define PAG_IDX_LOWER_TRIG   8
`define PAG_IDX_RSSI_TRIM    9
`define PAG_IDX_POSTFILTER   10

// field positions
`define PAG_F_SLOPE          2:0
`define PAG_F_BRIDGE_TRIM    4:0
`define PAG_F_EXT_BIAS       4:0
`define PAG_F_OUT_LEVEL      7:4
`define PAG_F_BIAS_SRC       3
`define PAG_F_PIN_CFG        2:0
`define PAG_F_LNA_HYST       6:5
`define PAG_F_LNA_THRES      4:1
`define PAG_F_FREEZE         0
`define PAG_F_SAT_MARGIN     5:3
`define PAG_F_TRIGGER        6:0
`define PAG_F_RSSI_OFFS      4:2
`define PAG_F_RSSI_AVG       1:0
`define PAG_F_PF_WINDOW      5:3
`define PAG_F_PF_SW_WINDOW   2:0
`define PAG_F_ADC_CODE       5:0

// ramp timing: base step in ps, clock period in ps (40 MHz)
`define PAG_STEP_BASE_PS     2400
`define PAG_CLK_PERIOD_PS    25000
`define PAG_LEVEL_OFF        4'h0

// bias pin drive modes
`define PAG_PIN_FLOAT        2'h0
`define PAG_PIN_SOURCE       2'h1
`define PAG_PIN_SINK         2'h2
`define PAG_PIN_SERVO        2'h3

// bias dac current in nA and servo target in uA
`define PAG_BIAS_FULL_NA     17'h13880
`define PAG_BIAS_STEP_NA     12'ha14
`define PAG_SERVO_FULL_UA    15'h55f0
`define PAG_SERVO_STEP_UA    9'h15d

`endif

// ### pag_ramp_timer.v
`timescale 1ns/1ps
`include "pag_defines.vh"

module pag_ramp_timer (
  input  wire       i_ref_clk,
  input  wire       i_rstn,
  input  wire [2:0] i_slope_code,
  input  wire [3:0] i_target,
  input  wire       i_tx_on,
  output reg  [3:0] o_level
);

  reg  [3:0] tick_r;
  wire [3:0] goal;
  wire [3:0] period;

  // cycles per step: 2^code * base, rounded up, never below one
  function [3:0] step_cycles;
    input [2:0] code;
    integer     ps;
    integer     cyc;
    begin
      ps          = `PAG_STEP_BASE_PS << code;
      cyc         = (ps + `PAG_CLK_PERIOD_PS - 1) / `PAG_CLK_PERIOD_PS;
      step_cycles = cyc[3:0];
      if (step_cycles == 4'h0) begin
        step_cycles = 4'h1;
      end
    end
  endfunction

  assign period = step_cycles(i_slope_code);
  assign goal   = i_tx_on ? i_target : `PAG_LEVEL_OFF;

  // one level step per period, up or down toward the goal
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_r  <= 4'h0;
      o_level <= `PAG_LEVEL_OFF;
    end else if (o_level == goal) begin
      tick_r <= 4'h0;
    end else if (tick_r + 4'h1 >= period) begin
      tick_r  <= 4'h0;
      o_level <= (o_level < goal) ? o_level + 4'h1 : o_level - 4'h1;
    end else begin
      tick_r <= tick_r + 4'h1;
    end
  end

endmodule // pag_ramp_timer

// ### pag_pin_ctrl.v
`timescale 1ns/1ps
`include "pag_defines.vh"

module pag_pin_ctrl (
  input  wire        i_ref_clk,
  input  wire        i_rstn,
  input  wire [2:0]  i_pin_cfg,
  input  wire [4:0]  i_bias_code,
  output reg         o_supply_on,
  output reg  [1:0]  o_bias_mode,
  output reg         o_servo_negative,
  output reg  [16:0] o_bias_na,
  output reg  [14:0] o_servo_ua
);

  reg  [1:0]  mode_nxt;
  reg         supply_nxt;
  wire [16:0] dac_step;
  wire [14:0] servo_step;
  wire [16:0] dac_na;
  wire [14:0] servo_ua;

  // products widened to the result width; the largest code never underflows
  assign dac_step   = {12'h0, i_bias_code} * `PAG_BIAS_STEP_NA;
  assign servo_step = {10'h0, i_bias_code} * `PAG_SERVO_STEP_UA;
  assign dac_na     = `PAG_BIAS_FULL_NA - dac_step;
  assign servo_ua   = `PAG_SERVO_FULL_UA - servo_step;

  // pin configuration decode; the reserved code parks the bias pin floating
  always @* begin
    supply_nxt = 1'b1;
    mode_nxt   = `PAG_PIN_FLOAT;
    case (i_pin_cfg)
      3'h1:    mode_nxt = `PAG_PIN_SOURCE;
      3'h2:    mode_nxt = `PAG_PIN_SINK;
      3'h3: begin
        supply_nxt = 1'b0;
        mode_nxt   = `PAG_PIN_SOURCE;
      end
      3'h4: begin
        supply_nxt = 1'b0;
        mode_nxt   = `PAG_PIN_SINK;
      end
      3'h5:    mode_nxt = `PAG_PIN_SERVO;
      3'h6:    mode_nxt = `PAG_PIN_SERVO;
      default: mode_nxt = `PAG_PIN_FLOAT;
    endcase
  end

  // registered pin drive; unused current figures read zero
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_supply_on      <= 1'b1;
      o_bias_mode      <= `PAG_PIN_FLOAT;
      o_servo_negative <= 1'b0;
      o_bias_na        <= 17'h0;
      o_servo_ua       <= 15'h0;
    end else begin
      o_supply_on      <= supply_nxt;
      o_bias_mode      <= mode_nxt;
      o_servo_negative <= (i_pin_cfg == 3'h6);
      o_bias_na        <= (i_pin_cfg >= 3'h1 && i_pin_cfg <= 3'h4) ? dac_na : 17'h0;
      o_servo_ua       <= (mode_nxt == `PAG_PIN_SERVO) ? servo_ua : 15'h0;
    end
  end

endmodule // pag_pin_ctrl

// ### pag_config_regs.v
`timescale 1ns/1ps
`include "pag_defines.vh"

module pag_config_regs (
  input  wire        i_ref_clk,
  input  wire        i_rstn,
  input  wire [9:0]  i_reg_addr,
  input  wire        i_reg_wr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_reg_rd,
  output reg  [7:0]  o_reg_rdata,
  output reg         o_reg_rvalid,
  input  wire        i_tx_on,
  input  wire [5:0]  i_adc_code,
  input  wire [7:0]  i_rssi_raw,
  output reg  [7:0]  o_rssi_readback,
  output wire [3:0]  o_amp_level_now,
  output wire [4:0]  o_amp_bridge_bias_trim,
  output wire        o_bias_ref_bandgap,
  output wire        o_amp_supply_pin_on,
  output wire [1:0]  o_amp_bias_pin_mode,
  output wire        o_amp_bias_servo_neg,
  output wire [16:0] o_amp_bias_pin_na,
  output wire [14:0] o_amp_supply_servo_ua,
  output wire [1:0]  o_gain_lna_hyst,
  output wire [3:0]  o_gain_lna_thres,
  output wire        o_gain_frozen,
  output wire [2:0]  o_gain_sat_margin,
  output wire [6:0]  o_gain_upper_trigger,
  output wire [6:0]  o_gain_target,
  output wire [6:0]  o_gain_lower_trigger,
  output wire [2:0]  o_rssi_offset,
  output wire [1:0]  o_rssi_avg_time,
  output wire [2:0]  o_gain_postfilter_window,
  output wire [2:0]  o_gain_postfilter_switch_window
);

  localparam NRW = `PAG_NUM_RW;

  // offsets and reset values of the read/write bank, entry 0 in the low bits
  localparam [10*NRW-1:0] RW_ADDRS = {
    `PAG_OFS_POSTFILTER, `PAG_OFS_RSSI_TRIM, `PAG_OFS_LOWER_TRIG,
    `PAG_OFS_TARGET,     `PAG_OFS_UPPER_TRIG, `PAG_OFS_SAT_MARGIN,
    `PAG_OFS_LNA_FREEZE, `PAG_OFS_EXT_LEVEL,  `PAG_OFS_EXT_BIAS,
    `PAG_OFS_BRIDGE,     `PAG_OFS_RAMP};
  localparam [8*NRW-1:0] RW_RESETS = {
    `PAG_RST_POSTFILTER, `PAG_RST_RSSI_TRIM, `PAG_RST_LOWER_TRIG,
    `PAG_RST_TARGET,     `PAG_RST_UPPER_TRIG, `PAG_RST_SAT_MARGIN,
    `PAG_RST_LNA_FREEZE, `PAG_RST_EXT_LEVEL,  `PAG_RST_EXT_BIAS,
    `PAG_RST_BRIDGE,     `PAG_RST_RAMP};

  wire [8*NRW-1:0] bank;
  wire [NRW-1:0]   hit;
  reg  [5:0]       adc_r;
  reg  [7:0]       rdata_nxt;
  wire [8:0]       rssi_sum;

  wire [7:0] ramp_reg;
  wire [7:0] bridge_reg;
  wire [7:0] ext_bias_reg;
  wire [7:0] ext_level_reg;
  wire [7:0] lna_reg;
  wire [7:0] sat_reg;
  wire [7:0] upper_reg;
  wire [7:0] target_reg;
  wire [7:0] lower_reg;
  wire [7:0] rssi_reg;
  wire [7:0] pf_reg;

  // one byte register per entry; all bits stored, reserved ones included,
  // so a read returns exactly what software last wrote
  genvar gi;
  generate
    for (gi = 0; gi < NRW; gi = gi + 1) begin : gen_rw
      reg [7:0] cfg_r;
      assign hit[gi] = (i_reg_addr == RW_ADDRS[10*gi +: 10]);
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cfg_r <= RW_RESETS[8*gi +: 8];
        end else if (i_reg_wr && hit[gi]) begin
          cfg_r <= i_reg_wdata;
        end
      end
      assign bank[8*gi +: 8] = cfg_r;
    end
  endgenerate

  // named views of the bank
  assign ramp_reg      = bank[8*`PAG_IDX_RAMP       +: 8];
  assign bridge_reg    = bank[8*`PAG_IDX_BRIDGE     +: 8];
  assign ext_bias_reg  = bank[8*`PAG_IDX_EXT_BIAS   +: 8];
  assign ext_level_reg = bank[8*`PAG_IDX_EXT_LEVEL  +: 8];
  assign lna_reg       = bank[8*`PAG_IDX_LNA_FREEZE +: 8];
  assign sat_reg       = bank[8*`PAG_IDX_SAT_MARGIN +: 8];
  assign upper_reg     = bank[8*`PAG_IDX_UPPER_TRIG +: 8];
  assign target_reg    = bank[8*`PAG_IDX_TARGET     +: 8];
  assign lower_reg     = bank[8*`PAG_IDX_LOWER_TRIG +: 8];
  assign rssi_reg      = bank[8*`PAG_IDX_RSSI_TRIM  +: 8];
  assign pf_reg        = bank[8*`PAG_IDX_POSTFILTER +: 8];

  // amplifier fields, straight from the register flops
  assign o_amp_bridge_bias_trim = bridge_reg[`PAG_F_BRIDGE_TRIM];
  assign o_bias_ref_bandgap     = ext_level_reg[`PAG_F_BIAS_SRC];

  // gain loop fields, straight from the register flops
  assign o_gain_lna_hyst       = lna_reg[`PAG_F_LNA_HYST];
  assign o_gain_lna_thres      = lna_reg[`PAG_F_LNA_THRES];
  assign o_gain_frozen         = lna_reg[`PAG_F_FREEZE];
  assign o_gain_sat_margin     = sat_reg[`PAG_F_SAT_MARGIN];
  assign o_gain_upper_trigger  = upper_reg[`PAG_F_TRIGGER];
  assign o_gain_target         = target_reg[`PAG_F_TRIGGER];
  assign o_gain_lower_trigger  = lower_reg[`PAG_F_TRIGGER];
  assign o_rssi_offset         = rssi_reg[`PAG_F_RSSI_OFFS];
  assign o_rssi_avg_time       = rssi_reg[`PAG_F_RSSI_AVG];
  assign o_gain_postfilter_window        = pf_reg[`PAG_F_PF_WINDOW];
  assign o_gain_postfilter_switch_window = pf_reg[`PAG_F_PF_SW_WINDOW];

  // power ramp toward the selected output level while transmitting
  pag_ramp_timer u_ramp (
    .i_ref_clk    (i_ref_clk),
    .i_rstn       (i_rstn),
    .i_slope_code (ramp_reg[`PAG_F_SLOPE]),
    .i_target     (ext_level_reg[`PAG_F_OUT_LEVEL]),
    .i_tx_on      (i_tx_on),
    .o_level      (o_amp_level_now)
  );

  // external amplifier supply and bias pin control
  pag_pin_ctrl u_pins (
    .i_ref_clk        (i_ref_clk),
    .i_rstn           (i_rstn),
    .i_pin_cfg        (ext_level_reg[`PAG_F_PIN_CFG]),
    .i_bias_code      (ext_bias_reg[`PAG_F_EXT_BIAS]),
    .o_supply_on      (o_amp_supply_pin_on),
    .o_bias_mode      (o_amp_bias_pin_mode),
    .o_servo_negative (o_amp_bias_servo_neg),
    .o_bias_na        (o_amp_bias_pin_na),
    .o_servo_ua       (o_amp_supply_servo_ua)
  );

  // converter code sampled every cycle; software only reads it
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      adc_r <= 6'h0;
    end else begin
      adc_r <= i_adc_code;
    end
  end

  // offset added to signal strength; saturate rather than wrap so a
  // strong signal never reads back as a weak one
  assign rssi_sum = {1'b0, i_rssi_raw} + {6'h0, rssi_reg[`PAG_F_RSSI_OFFS]};

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rssi_readback <= 8'h0;
    end else begin
      o_rssi_readback <= rssi_sum[8] ? 8'hff : rssi_sum[7:0];
    end
  end

  // read mux; unmapped offsets read zero, writes to them are dropped
  integer k;
  always @* begin
    rdata_nxt = 8'h0;
    for (k = 0; k < NRW; k = k + 1) begin
      if (hit[k]) begin
        rdata_nxt = bank[8*k +: 8];
      end
    end
    if (i_reg_addr == `PAG_OFS_ADC_RBK) begin
      rdata_nxt = {2'h0, adc_r};
    end
  end

  // read data registered, valid one cycle after the strobe
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata  <= 8'h0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_nxt;
      end
    end
  end

endmodule // pag_config_regs

// ### pag_config_regs_props.sv
`timescale 1ns/1ps
module pag_config_regs_props (
  input wire        i_ref_clk,
  input wire        i_rstn,
  input wire [9:0]  i_reg_addr,
  input wire        i_reg_wr,
  input wire [7:0]  i_reg_wdata,
  input wire        i_reg_rd,
  input wire        i_tx_on,
  input wire [5:0]  i_adc_code,
  input wire [7:0]  o_reg_rdata,
  input wire        o_reg_rvalid,
  input wire [3:0]  o_amp_level_now,
  input wire        o_amp_supply_pin_on,
  input wire [1:0]  o_amp_bias_pin_mode,
  input wire [14:0] o_amp_supply_servo_ua,
  input wire        o_gain_frozen,
  input wire [6:0]  o_gain_target
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // level moves at most one step per edge
  property p_one_step;
    (o_amp_level_now == $past(o_amp_level_now)) ||
    (o_amp_level_now == $past(o_amp_level_now) + 4'h1) ||
    (o_amp_level_now + 4'h1 == $past(o_amp_level_now));
  endproperty

  a_rvalid_after_rd: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read strobe gave no valid pulse");
  a_rvalid_has_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("valid pulse without a read");
  a_target_written: assert property (i_reg_wr && i_reg_addr == 10'h3b7 |=>
    {1'b0, o_gain_target} == ($past(i_reg_wdata) & 8'h7f))
    else $error("target field not loaded");
  a_freeze_written: assert property (i_reg_wr && i_reg_addr == 10'h3b2 |=>
    {7'h0, o_gain_frozen} == ($past(i_reg_wdata) & 8'h01))
    else $error("freeze bit not loaded");
  a_adc_readback: assert property (i_reg_rd && i_reg_addr == 10'h3ae |=>
    o_reg_rdata == {2'h0, $past(i_adc_code, 2)})
    else $error("converter readback wrong");
  a_level_one_step: assert property (p_one_step)
    else $error("level jumped more than one step");
  a_no_rise_idle: assert property (!i_tx_on |=> o_amp_level_now <= $past(o_amp_level_now))
    else $error("level rose with transmit off");
  a_supply_off_mode: assert property (i_reg_wr && i_reg_addr == 10'h3aa &&
    (i_reg_wdata[2:0] == 3'h3 || i_reg_wdata[2:0] == 3'h4) |=> ##1 !o_amp_supply_pin_on)
    else $error("supply pin not off");
  a_servo_mode_only: assert property (o_amp_supply_servo_ua != 15'h0 |->
    o_amp_bias_pin_mode == 2'h3)
    else $error("servo current outside servo mode");

  c_read: cover property (i_reg_rd ##1 o_reg_rvalid);
  c_ramped: cover property (o_amp_level_now == 4'h5);
  c_servo: cover property (o_amp_bias_pin_mode == 2'h3);
endmodule // pag_config_regs_props

bind pag_config_regs pag_config_regs_props u_props (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
  .i_tx_on(i_tx_on), .i_adc_code(i_adc_code), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .o_amp_level_now(o_amp_level_now),
  .o_amp_supply_pin_on(o_amp_supply_pin_on), .o_amp_bias_pin_mode(o_amp_bias_pin_mode),
  .o_amp_supply_servo_ua(o_amp_supply_servo_ua), .o_gain_frozen(o_gain_frozen),
  .o_gain_target(o_gain_target));

// ### pag_config_regs_bench.sv
`timescale 1ns/1ps
`include "pag_defines.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module pag_config_regs_bench;
  logic        clk = 0, rstn = 0, wr = 0, rd = 0, tx = 0;
  logic [9:0]  addr = 0;
  logic [7:0]  wd = 0, raw = 8'h10, rdata, rssi;
  logic [5:0]  adc = 6'h2b;
  logic        rvalid, bg, sup, neg;
  logic [3:0]  lvl;
  logic [4:0]  trim;
  logic [1:0]  mode;
  logic [16:0] na;
  logic [14:0] ua;
  wire  [41:0] f;
  int          mismatches = 0, total_checks = 0, i;
  logic [9:0]  ra [11] = '{`PAG_OFS_RAMP, `PAG_OFS_BRIDGE, `PAG_OFS_EXT_BIAS,
    `PAG_OFS_EXT_LEVEL, `PAG_OFS_LNA_FREEZE, `PAG_OFS_SAT_MARGIN, `PAG_OFS_UPPER_TRIG,
    `PAG_OFS_TARGET, `PAG_OFS_LOWER_TRIG, `PAG_OFS_RSSI_TRIM, `PAG_OFS_POSTFILTER};
  logic [7:0]  rv [11] = '{8'h07, 8'h0d, 8'h00, 8'hf1, 8'h30, 8'h90, 8'h2e,
    8'h23, 8'h18, 8'h13, 8'h2d};

  pag_config_regs dut (
    .i_ref_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_tx_on(tx), .i_adc_code(adc), .i_rssi_raw(raw), .o_rssi_readback(rssi),
    .o_amp_level_now(lvl), .o_amp_bridge_bias_trim(trim), .o_bias_ref_bandgap(bg),
    .o_amp_supply_pin_on(sup), .o_amp_bias_pin_mode(mode), .o_amp_bias_servo_neg(neg),
    .o_amp_bias_pin_na(na), .o_amp_supply_servo_ua(ua), .o_gain_lna_hyst(f[1:0]),
    .o_gain_lna_thres(f[5:2]), .o_gain_frozen(f[6]), .o_gain_sat_margin(f[9:7]),
    .o_gain_upper_trigger(f[16:10]), .o_gain_target(f[23:17]),
    .o_gain_lower_trigger(f[30:24]), .o_rssi_offset(f[33:31]),
    .o_rssi_avg_time(f[35:34]), .o_gain_postfilter_window(f[38:36]),
    .o_gain_postfilter_switch_window(f[41:39]));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // one-cycle write strobe, released at the taking edge
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // valid shows at the taking edge, checked 1 ns after it
  task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // cut a hang short, far beyond the few hundred cycles used
  initial begin
    #(25 * 5000);
    mismatches++;
    wrap_up;
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 11; i++) rd_reg(ra[i], rv[i]);
    rd_reg(`PAG_OFS_ADC_RBK, 8'h2b);
    `CHK(f, ({3'h5, 3'h5, 2'h3, 3'h4, 7'd24, 7'd35, 7'd46, 3'h2, 1'h0, 4'h8, 2'h1}))
    `CHK(rssi, 8'h14)
    // whole bytes kept, reserved bits too; readback and holes refuse writes
    for (i = 0; i < 11; i++) wr_reg(ra[i], 8'ha0 + i[7:0]);
    wr_reg(`PAG_OFS_ADC_RBK, 8'hff);
    // a new converter code must show up, not the refused write
    adc <= 6'h15;
    wr_reg(10'h3a0, 8'hff);
    for (i = 0; i < 11; i++) rd_reg(ra[i], 8'ha0 + i[7:0]);
    rd_reg(`PAG_OFS_ADC_RBK, 8'h15);
    rd_reg(10'h3a0, 8'h00);
    for (i = 0; i < 11; i++) wr_reg(ra[i], rv[i]);
    // alternate modulation settings reach the field outputs
    wr_reg(`PAG_OFS_UPPER_TRIG, 8'd55);
    wr_reg(`PAG_OFS_LOWER_TRIG, 8'd29);
    wr_reg(`PAG_OFS_TARGET, 8'd42);
    wr_reg(`PAG_OFS_POSTFILTER, 8'h24);
    wr_reg(`PAG_OFS_BRIDGE, 8'd21);
    wr_reg(`PAG_OFS_LNA_FREEZE, 8'h31);
    wr_reg(`PAG_OFS_RSSI_TRIM, 8'h1c);
    wr_reg(`PAG_OFS_SAT_MARGIN, 8'ha8);
    raw <= 8'h20;
    repeat (2) @(posedge clk);
    #1 `CHK(f, ({3'h4, 3'h4, 2'h0, 3'h7, 7'd29, 7'd42, 7'd55, 3'h5, 1'h1, 4'h8, 2'h1}))
    `CHK(trim, 5'd21)
    `CHK(rssi, 8'h27)
    // strong signal plus offset must clamp, not wrap
    @(posedge clk);
    raw <= 8'hfe;
    repeat (2) @(posedge clk);
    #1 `CHK(rssi, 8'hff)
    // every pin configuration with bias code 10
    wr_reg(`PAG_OFS_EXT_BIAS, 8'h0a);
    for (i = 0; i < 8; i++) begin
      wr_reg(`PAG_OFS_EXT_LEVEL, {4'hf, i[0], i[2:0]});
      repeat (2) @(posedge clk);
      #1 `CHK(({bg, sup, neg}), ({i[0], (i != 3 && i != 4), (i == 6)}))
      `CHK(mode, (i == 0 || i == 7) ? 2'h0 : (i > 4) ? 2'h3 : (i[0] ? 2'h1 : 2'h2))
      `CHK(na, (i >= 1 && i <= 4) ? 17'd54200 : 17'd0)
      `CHK(ua, (i == 5 || i == 6) ? 15'd18510 : 15'd0)
    end
    // slowest slope: thirteen cycles per step, then fastest
    wr_reg(`PAG_OFS_EXT_LEVEL, 8'h51);
    tx <= 1'b1;
    repeat (20) @(posedge clk);
    #1 `CHK(lvl, 4'h1)
    repeat (30) @(posedge clk);
    #1 `CHK(lvl, 4'h3)
    wr_reg(`PAG_OFS_RAMP, 8'h00);
    repeat (10) @(posedge clk);
    #1 `CHK(lvl, 4'h5)
    @(posedge clk);
    tx <= 1'b0;
    repeat (10) @(posedge clk);
    #1 `CHK(lvl, 4'h0)
    // second reset in mid-run reloads defaults
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(`PAG_OFS_TARGET, 8'h23);
    wrap_up;
  end
endmodule // pag_config_regs_bench
